// *** hw/nvac_top.sv ***
// Purpose : Register front end of the data EEPROM: read, unlock, write.
// Assumes : The core issues at most one register access per cycle, and
//           por_i tells a power-up (or brown-out) reset from others.
// Notes   : Register reads answer one cycle after the request.
//           Writes are refused while the power-up timer runs.
//           A reset that cuts a write leaves that byte erased.
//
// Summary of operation
// - Setting read-start puts the addressed byte into the data register next cycle.
// - Data register holds a read byte until another read, a core write or a reset.
// - A write starts only after 55h, then AAh, then write-start in order.
// - The cycle spacing of the unlock sequence must match exactly or no write.
// - Write-start cannot set unless write-allow is already set.
// - Hardware never clears write-allow except on a reset of any kind.
// - Clearing write-allow after start leaves the running write untouched.
// - At write end hardware clears write-start and sets done flag bit 7.
// - Only a core write or a reset clears the done flag.
// - Power-up clears write-allow.
// - No array write starts during the 72 ms power-up timer.
// - Protection fuse at 0 protects data yet core access still works.
// - Unlock port stores nothing; it only takes the unlock writes.
// - Data register resets to zero on every reset.
// - Address register resets to zero; its bit 7 reads zero.
// - Read-start and write-start are set only by core, cleared by hardware.
// - A non-power-up reset during a write sets the abort flag; every reset clears address and data.
// - Reading the unlock port returns zero.
// - Only seven address bits select one of 128 locations.
module nvac_top #(
  parameter int PWRT_CYCLES  = nvac_pkg::PWRT_CYCLES,
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       por_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       data_protect_fuse_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_rvalid_o,
  output logic            write_busy_o,
  output logic            pwrt_active_o,
  output logic            data_protected_o
);

  // Width of the power-up timer, wide enough to hold its load value
  localparam int PW = $clog2(PWRT_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Timer must fit its counter; a zero-length write has no done pulse
  if (PWRT_CYCLES < 1 || PWRT_CYCLES >= (1 << 30)) begin : g_bad_pwrt
    $error("PWRT_CYCLES out of range");
  end
  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << 20)) begin : g_bad_write
    $error("WRITE_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    nvac_pkg::nvac_unlock_e      ul;
    logic [2:0]                  ul_cnt;
    logic [nvac_pkg::DATA_W-1:0] data;
    logic [nvac_pkg::ADDR_W-1:0] addr;
    logic                        rd;
    logic                        wr;
    logic                        allow;
    logic                        abort;
    logic                        done;
    logic [PW-1:0]               pwrt;
    logic [7:0]                  rdata;
    logic                        rvalid;
    logic                        fuse_s1;
    logic                        fuse_s2;
  } nvac_top_s;

  // All state in one record; s_d is its next value
  nvac_top_s s_q;
  nvac_top_s s_d;

  // Request path to the array
  nvac_mem_if mem ();

  // Decoded write strobes, the qualified write start and the control read view
  logic       wr_flags;
  logic       wr_data;
  logic       wr_addr;
  logic       wr_ctrl;
  logic       wr_unlock;
  logic       wr_block;
  logic       start_ok;
  logic       start;
  logic [7:0] ctrl_view;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Full 8-bit offsets; the bank select is resolved by the core
  assign wr_flags  = sfr_wr_i && (sfr_addr_i == nvac_pkg::FLAGS_OFS);
  assign wr_data   = sfr_wr_i && (sfr_addr_i == nvac_pkg::DATA_OFS);
  assign wr_addr   = sfr_wr_i && (sfr_addr_i == nvac_pkg::ADDR_OFS);
  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == nvac_pkg::CTRL_OFS);
  assign wr_unlock = sfr_wr_i && (sfr_addr_i == nvac_pkg::UNLOCK_OFS);
  assign wr_block  = wr_data || wr_addr || wr_ctrl || wr_unlock;

  // Upper four control bits are unimplemented and read zero
  assign ctrl_view = {4'h0, s_q.abort, s_q.allow, s_q.wr, s_q.rd};

  // ----------------------------------------------------------------------
  // Write start qualification
  // ----------------------------------------------------------------------
  // Cycle count of the unlock: the second key must land exactly
  // UNLOCK_GAP_CYC cycles after the first, and write-start exactly
  // START_GAP_CYC after the second. An interrupt between steps
  // stretches the spacing, so the attempt is dropped and software
  // must start over from the first key.
  // All interlocks must agree in the cycle the write-start bit is written
  assign start_ok = (s_q.ul == nvac_pkg::UL_SECOND)
                 && (s_q.ul_cnt == nvac_pkg::START_GAP_CYC)
                 && s_q.allow
                 && !s_q.wr
                 && !mem.busy
                 && (s_q.pwrt == '0);
  assign start = wr_ctrl && sfr_wdata_i[nvac_pkg::CTRL_WR_BIT] && start_ok;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (rst_i) begin
      // Every reset clears the data path; abort flag and power-up
      // timer depend on which kind of reset this is
      s_d.ul     = nvac_pkg::UL_IDLE;
      s_d.ul_cnt = 3'h0;
      s_d.data   = nvac_pkg::DATA_RST;
      s_d.addr   = nvac_pkg::ADDR_RST;
      s_d.rd     = 1'b0;
      s_d.wr     = 1'b0;
      s_d.allow  = 1'b0;
      s_d.done   = 1'b0;
      s_d.rdata  = 8'h00;
      s_d.rvalid = 1'b0;
      // A non-power-up reset that cuts a running write is reported after it
      if (!por_i && s_q.wr) begin
        s_d.abort = 1'b1;
      end else if (por_i) begin
        s_d.abort = 1'b0;
      end
      // Only a power-up rearms the write blocking timer
      if (por_i) begin
        s_d.pwrt = PW'(PWRT_CYCLES);
      end
      s_d.fuse_s1 = 1'b1;
      s_d.fuse_s2 = 1'b1;
    end else begin
      // Fuse pin is static but asynchronous, so resample it
      s_d.fuse_s1 = data_protect_fuse_i;
      s_d.fuse_s2 = s_q.fuse_s1;

      // Power-up timer counts down to zero and stays there
      if (s_q.pwrt != '0) begin
        s_d.pwrt = s_q.pwrt - PW'(1);
      end

      // Unlock spacing counter saturates so late steps never match
      if (s_q.ul_cnt != 3'h7) begin
        s_d.ul_cnt = s_q.ul_cnt + 3'h1;
      end
      unique case (s_q.ul)
        nvac_pkg::UL_IDLE: begin
          s_d.ul = nvac_pkg::UL_IDLE;
        end
        nvac_pkg::UL_FIRST: begin
          if (s_q.ul_cnt > nvac_pkg::UNLOCK_GAP_CYC) begin
            s_d.ul = nvac_pkg::UL_IDLE;
          end
        end
        nvac_pkg::UL_SECOND: begin
          if (s_q.ul_cnt > nvac_pkg::START_GAP_CYC) begin
            s_d.ul = nvac_pkg::UL_IDLE;
          end
        end
        default: begin
          s_d.ul = nvac_pkg::UL_IDLE;
        end
      endcase

      // Any stray block write breaks a sequence in progress
      if (wr_block) begin
        s_d.ul = nvac_pkg::UL_IDLE;
      end

      // Unlock port keeps no value; writes only advance the sequence
      if (wr_unlock) begin
        s_d.ul_cnt = 3'h1;
        if (sfr_wdata_i == nvac_pkg::UNLOCK_KEY1) begin
          s_d.ul = nvac_pkg::UL_FIRST;
        end else if (sfr_wdata_i == nvac_pkg::UNLOCK_KEY2
                     && s_q.ul == nvac_pkg::UL_FIRST
                     && s_q.ul_cnt == nvac_pkg::UNLOCK_GAP_CYC) begin
          s_d.ul = nvac_pkg::UL_SECOND;
        end
      end

      // Read-start lives for one cycle only
      s_d.rd = 1'b0;

      // Plain register writes
      if (wr_data) begin
        s_d.data = sfr_wdata_i;
      end
      if (wr_addr) begin
        s_d.addr = sfr_wdata_i[nvac_pkg::ADDR_W-1:0];
      end

      // Control write: allow and abort are plain, rd and wr set only
      if (wr_ctrl) begin
        s_d.allow = sfr_wdata_i[nvac_pkg::CTRL_ALLOW_BIT];
        s_d.abort = sfr_wdata_i[nvac_pkg::CTRL_ABORT_BIT];
        if (sfr_wdata_i[nvac_pkg::CTRL_RD_BIT]) begin
          s_d.rd   = 1'b1;
          s_d.data = mem.rd_data;
        end
        if (start) begin
          s_d.wr = 1'b1;
        end
      end

      // Done flag: core writes it, completion sets it and wins
      if (wr_flags) begin
        s_d.done = sfr_wdata_i[nvac_pkg::FLAG_DONE_BIT];
      end
      if (mem.done) begin
        s_d.wr   = 1'b0;
        s_d.done = 1'b1;
      end

      // Register read answer, registered for a clean output
      s_d.rvalid = sfr_rd_i;
      s_d.rdata  = 8'h00;
      if (sfr_rd_i) begin
        unique case (sfr_addr_i)
          nvac_pkg::FLAGS_OFS:  s_d.rdata = {s_q.done, 7'h00};
          nvac_pkg::DATA_OFS:   s_d.rdata = s_q.data;
          nvac_pkg::ADDR_OFS:   s_d.rdata = {1'b0, s_q.addr};
          nvac_pkg::CTRL_OFS:   s_d.rdata = ctrl_view;
          nvac_pkg::UNLOCK_OFS: s_d.rdata = 8'h00;
          default:              s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  // Array latches address and data at start, so a later allow clear,
  // address or data write cannot disturb the running cycle
  assign mem.rd_addr = s_q.addr;
  assign mem.start   = start && !rst_i;
  assign mem.wr_addr = s_q.addr;
  assign mem.wr_data = s_q.data;

  nvac_array #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) nvac_array_inst (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mem   (mem)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Read answer straight from its flops
  assign sfr_rdata_o      = s_q.rdata;
  assign sfr_rvalid_o     = s_q.rvalid;
  assign write_busy_o     = s_q.wr;
  // Lets software wait out the power-up timer before its first write
  assign pwrt_active_o    = (s_q.pwrt != '0);
  // Protection only bars an external programmer; core access is unchanged
  assign data_protected_o = !s_q.fuse_s2;

endmodule

// *** hw/nvac_pkg.sv ***
// Purpose : Shared constants and types of the data EEPROM access control.
// Assumes : One core instruction cycle per clk_i edge, 100 MHz clock.
// Notes   : Every offset, bit position, cycle count and the data and address reset values live here.
package nvac_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLAGS_OFS  = 8'h0C;
  localparam logic [7:0] DATA_OFS   = 8'h9A;
  localparam logic [7:0] ADDR_OFS   = 8'h9B;
  localparam logic [7:0] CTRL_OFS   = 8'h9C;
  localparam logic [7:0] UNLOCK_OFS = 8'h9D;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int         FLAG_DONE_BIT  = 7;
  localparam int         CTRL_ABORT_BIT = 3;
  localparam int         CTRL_ALLOW_BIT = 2;
  localparam int         CTRL_WR_BIT    = 1;
  localparam int         CTRL_RD_BIT    = 0;
  localparam logic [7:0] UNLOCK_KEY1    = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2    = 8'hAA;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [6:0] ADDR_RST       = 7'h00;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int         ADDR_W          = 7;
  localparam int         DATA_W          = 8;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         PWRT_TIME_MS    = 72;
  localparam int         PWRT_CYCLES     = (PWRT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         WRITE_CYCLES    = 500;
  localparam logic [2:0] UNLOCK_GAP_CYC  = 3'h2;
  localparam logic [2:0] START_GAP_CYC   = 3'h1;

  // Unlock sequence progress
  typedef enum logic [1:0] {
    UL_IDLE,
    UL_FIRST,
    UL_SECOND
  } nvac_unlock_e;

endpackage

// *** hw/nvac_mem_if.sv ***
// Purpose : Carries array requests between the controller and the array.
// Assumes : Single clock domain, all signals on clk_i.
// Notes   : start is a one-cycle pulse; done is a one-cycle pulse.
interface nvac_mem_if;
  logic [nvac_pkg::ADDR_W-1:0] rd_addr;
  logic [nvac_pkg::DATA_W-1:0] rd_data;
  logic                        start;
  logic [nvac_pkg::ADDR_W-1:0] wr_addr;
  logic [nvac_pkg::DATA_W-1:0] wr_data;
  logic                        busy;
  logic                        done;

  modport ctrl  (output rd_addr, start, wr_addr, wr_data, input rd_data, busy, done);
  modport array (input rd_addr, start, wr_addr, wr_data, output rd_data, busy, done);
endinterface

// *** hw/nvac_array.sv ***
// Purpose : 128 byte array with self-timed erase-then-program write.
// Assumes : start only arrives while busy is low.
// Notes   : Address and data are latched at start, so the write is
//           immune to later register changes.
module nvac_array #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  nvac_mem_if.array mem
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // Timer counter width is bounded; zero cycles would never finish
  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << 20)) begin : g_bad_write
    $error("WRITE_CYCLES out of range");
  end

  typedef struct packed {
    logic                        busy;
    logic [CW-1:0]               cnt;
    logic [nvac_pkg::ADDR_W-1:0] addr;
    logic [nvac_pkg::DATA_W-1:0] data;
  } nvac_arr_s;

  nvac_arr_s                   s_q;
  nvac_arr_s                   s_d;
  logic [nvac_pkg::DATA_W-1:0] cells [1 << nvac_pkg::ADDR_W];

  // ----------------------------------------------------------------------
  // Write timer
  // ----------------------------------------------------------------------
  // Busy lasts exactly WRITE_CYCLES cycles from the start pulse
  always_comb begin
    s_d = s_q;
    if (rst_i) begin
      s_d = '0;
    end else if (mem.start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt  = CW'(WRITE_CYCLES - 1);
      s_d.addr = mem.wr_addr;
      s_d.data = mem.wr_data;
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // Erase at start, program at the end; a reset in between leaves the byte erased
  always_ff @(posedge clk_i) begin
    if (mem.start && !s_q.busy && !rst_i) begin
      cells[mem.wr_addr] <= nvac_pkg::ERASED_BYTE;
    end else if (mem.done) begin
      cells[s_q.addr] <= s_q.data;
    end
  end

  assign mem.busy    = s_q.busy;
  assign mem.done    = s_q.busy && (s_q.cnt == '0) && !rst_i;
  assign mem.rd_data = cells[mem.rd_addr];

endmodule

// *** verification/nvac_properties.sv ***
// Purpose : Port timing checks of the EEPROM register front end.
// Assumes : One clock, synchronous active-high reset.
// Notes   : Bound to nvac_top below the module.
module nvac_properties #(
  parameter int PWRT_CYCLES  = 20,
  parameter int WRITE_CYCLES = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_rd_i,
  input wire logic       data_protect_fuse_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_rvalid_o,
  input wire logic       write_busy_o,
  input wire logic       pwrt_active_o,
  input wire logic       data_protected_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Helpers
  // ------
  logic        key1, key2, go, rd_data;
  logic [15:0] busy_len_q;
  // Unlock steps, write start and data register reads as seen on the bus
  assign key1 = sfr_wr_i && sfr_addr_i == nvac_pkg::UNLOCK_OFS && sfr_wdata_i == 8'h55;
  assign key2 = sfr_wr_i && sfr_addr_i == nvac_pkg::UNLOCK_OFS && sfr_wdata_i == 8'hAA;
  assign go = sfr_wr_i && sfr_addr_i == nvac_pkg::CTRL_OFS && sfr_wdata_i[1];
  assign rd_data = sfr_rd_i && !sfr_wr_i && sfr_addr_i == nvac_pkg::DATA_OFS;
  // Busy run length; cleared whenever idle
  always_ff @(posedge clk_i) begin
    busy_len_q <= (rst_i || !write_busy_o) ? 16'h0000 : busy_len_q + 16'h0001;
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_data_twice; rd_data ##1 rd_data; endsequence
  property p_rd_answer; sfr_rd_i |=> sfr_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_idle; !sfr_rd_i |=> !sfr_rvalid_o && sfr_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unlock_zero; sfr_rd_i && sfr_addr_i == nvac_pkg::UNLOCK_OFS |=> sfr_rdata_o == 8'h00; endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port not zero");
  property p_addr_msb; sfr_rd_i && sfr_addr_i == nvac_pkg::ADDR_OFS |=> !sfr_rdata_o[7]; endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("address bit 7 set");
  property p_start;
    $rose(write_busy_o) |-> $past(go) && $past(key2, 2) && $past(key1, 4);
  endproperty
  a_start: assert property (p_start) else $error("write without exact unlock");
  property p_pwrt; pwrt_active_o |=> !$rose(write_busy_o); endproperty
  a_pwrt: assert property (p_pwrt) else $error("write during power-up wait");
  property p_wr_len; $fell(write_busy_o) |-> busy_len_q == WRITE_CYCLES; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write length wrong");
  property p_data_hold; s_data_twice |=> $stable(sfr_rdata_o); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data register drifted");
  property p_fuse_sync;
    !$past(rst_i) && !$past(rst_i, 2) |-> data_protected_o == !$past(data_protect_fuse_i, 2);
  endproperty
  a_fuse_sync: assert property (p_fuse_sync) else $error("protect status lags fuse");
endmodule
bind nvac_top nvac_properties #(.PWRT_CYCLES(PWRT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
  nvac_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rd_i(sfr_rd_i), .data_protect_fuse_i(data_protect_fuse_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .write_busy_o(write_busy_o),
  .pwrt_active_o(pwrt_active_o), .data_protected_o(data_protected_o));

// *** verification/nvac_core.sv ***
// Purpose : Behavioural core issuing register reads and writes.
// Assumes : Every task is entered 1 ns after a rising edge.
// Notes   : Strobes stay up between calls; idle lowers them.
module nvac_core (
  input  wire logic       clk_i,
  input  wire logic [7:0] sfr_rdata_i,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            sfr_rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet bus at time zero
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o    = 1'b0;
  end
  // One write, taken at the next edge
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_o  = a;
    sfr_wdata_o = d;
    sfr_wr_o    = 1'b1;
    sfr_rd_o    = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  // One read; the answer is there just after the taking edge
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_o = a;
    sfr_wr_o   = 1'b0;
    sfr_rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    d = sfr_rdata_i;
  endtask
  // Bus quiet for n cycles
  task automatic idle(input int n);
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // Unlock and start; no interrupts here, so the spacing never slips
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input logic gap,
                        input logic [7:0] ctl);
    put(nvac_pkg::UNLOCK_OFS, k1);
    if (gap) idle(1);
    put(nvac_pkg::UNLOCK_OFS, k2);
    put(nvac_pkg::CTRL_OFS, ctl);
    idle(1);
  endtask
endmodule

// *** verification/test_data_eeprom_access_control.sv ***
// Purpose : Self-checking bench of the EEPROM register front end.
// Assumes : Short power-up wait and write time for a quick run.
// Notes   : The core model drives the register port.
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH at %0t: got %h want %h", $time, got, exp); end end
module test_data_eeprom_access_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i, rst_i, por_i, fuse, wr, rd, rvalid, busy, pwrt, prot;
  logic [7:0] addr, wdata, rdata, got;
  int         errors, tests_run, cycles;
  nvac_top #(.PWRT_CYCLES(20), .WRITE_CYCLES(8)) nvac_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .data_protect_fuse_i(fuse), .sfr_rdata_o(rdata),
    .sfr_rvalid_o(rvalid), .write_busy_o(busy), .pwrt_active_o(pwrt),
    .data_protected_o(prot));
  nvac_core nvac_core_inst (.clk_i(clk_i), .sfr_rdata_i(rdata), .sfr_addr_o(addr),
    .sfr_wr_o(wr), .sfr_wdata_o(wdata), .sfr_rd_o(rd));
  // ------
  // Clock and hang guard
  // ------
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  // A full run needs under a hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("MISMATCH at %0t: run timed out", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] want);
    nvac_core_inst.get(a, got);
    `CHK(rvalid, 1'b1)
    `CHK(got, want)
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40 && busy !== 1'b0; i++) nvac_core_inst.idle(1);
    `CHK(busy, 1'b0)
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    `CHK(pwrt, 1'b1)
    expect_reg(nvac_pkg::DATA_OFS, 8'h00);
    expect_reg(nvac_pkg::ADDR_OFS, 8'h00);
    expect_reg(nvac_pkg::CTRL_OFS, 8'h00);
    expect_reg(nvac_pkg::FLAGS_OFS, 8'h00);
    nvac_core_inst.put(nvac_pkg::CTRL_OFS, 8'h04);
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b1, 8'h06);
    `CHK(busy, 1'b0)
    for (int i = 0; i < 40 && pwrt !== 1'b0; i++) nvac_core_inst.idle(1);
    `CHK(pwrt, 1'b0)
    $display("test reset and power-up wait done");
  endtask
  task automatic t_write();
    fuse = ~fuse;
    nvac_core_inst.put(nvac_pkg::DATA_OFS, 8'hA5);
    nvac_core_inst.put(nvac_pkg::ADDR_OFS, 8'h05);
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b1, 8'h06);
    `CHK(busy, 1'b1)
    wait_done();
    expect_reg(nvac_pkg::FLAGS_OFS, 8'h80);
    expect_reg(nvac_pkg::CTRL_OFS, 8'h04);
    nvac_core_inst.put(nvac_pkg::FLAGS_OFS, 8'h00);
    expect_reg(nvac_pkg::FLAGS_OFS, 8'h00);
    nvac_core_inst.put(nvac_pkg::DATA_OFS, 8'h00);
    nvac_core_inst.put(nvac_pkg::ADDR_OFS, 8'h85);
    nvac_core_inst.put(nvac_pkg::CTRL_OFS, 8'h05);
    expect_reg(nvac_pkg::DATA_OFS, 8'hA5);
    expect_reg(nvac_pkg::DATA_OFS, 8'hA5);
    expect_reg(nvac_pkg::ADDR_OFS, 8'h05);
    `CHK(prot, 1'b1)
    nvac_core_inst.put(nvac_pkg::DATA_OFS, 8'h3C);
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b1, 8'h06);
    nvac_core_inst.put(nvac_pkg::CTRL_OFS, 8'h00);
    `CHK(busy, 1'b1)
    wait_done();
    nvac_core_inst.put(nvac_pkg::CTRL_OFS, 8'h01);
    expect_reg(nvac_pkg::DATA_OFS, 8'h3C);
    $display("test write and read back done");
  endtask
  task automatic t_refuse();
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b1, 8'h06);
    `CHK(busy, 1'b0)
    nvac_core_inst.put(nvac_pkg::CTRL_OFS, 8'h06);
    nvac_core_inst.idle(1);
    `CHK(busy, 1'b0)
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b0, 8'h06);
    `CHK(busy, 1'b0)
    nvac_core_inst.unlock(8'hAA, 8'h55, 1'b1, 8'h06);
    `CHK(busy, 1'b0)
    expect_reg(nvac_pkg::UNLOCK_OFS, 8'h00);
    $display("test refused starts done");
  endtask
  task automatic t_abort();
    nvac_core_inst.unlock(8'h55, 8'hAA, 1'b1, 8'h06);
    `CHK(busy, 1'b1)
    rst_i = 1'b1;
    por_i = ~por_i;
    nvac_core_inst.idle(2);
    rst_i = 1'b0;
    expect_reg(nvac_pkg::CTRL_OFS, 8'h08);
    expect_reg(nvac_pkg::DATA_OFS, 8'h00);
    expect_reg(nvac_pkg::ADDR_OFS, 8'h00);
    $display("test reset during write done");
  endtask
  // Main sequence
  initial begin
    rst_i = 1'b1;
    por_i = 1'b1;
    fuse  = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_write();
    t_refuse();
    t_abort();
    close_out();
  end
endmodule
